/* File: include/sfadm_pkg.sv */
// Constants and types shared by the flow acknowledge and delete framer.
// Assumes one MAC clock; all message fields arrive already parsed.
package sfadm_pkg;
	localparam int TID_W  = 16;
	localparam int FLOW_W = 32;
	localparam int CONF_W = 8;
	localparam int KEY_W  = 4;
	localparam int PAR_W  = 8;

	// Confirmation codes; only the success value is fixed by the protocol.
	localparam logic [CONF_W-1:0] CONF_OK        = 8'h00;
	localparam logic [CONF_W-1:0] CONF_REJECT    = 8'h01;
	localparam logic [CONF_W-1:0] CONF_NOT_FOUND = 8'h02;

	localparam logic [TID_W-1:0] TID_RESET = 16'h0001;
	localparam logic [TID_W-1:0] TID_STEP  = 16'h0001;

	typedef enum logic [2:0] {
		MSG_NONE    = 3'h0,
		MSG_SC_RSP  = 3'h1,
		MSG_SC_ACK  = 3'h2,
		MSG_DEL_REQ = 3'h3,
		MSG_DEL_RSP = 3'h4
	} sfadm_msg_t;

	// Beat kinds double as transmit states, Gray coded along the path.
	typedef enum logic [2:0] {
		BEAT_IDLE = 3'h0,
		BEAT_HDR  = 3'h1,
		BEAT_ERR  = 3'h3,
		BEAT_FUP  = 3'h2,
		BEAT_FDN  = 3'h6,
		BEAT_KEY  = 3'h7,
		BEAT_MAC  = 3'h5
	} sfadm_beat_t;
endpackage

/* File: core/sfadm_framer.sv */
// Builds acknowledge, delete request and delete response messages.
// Assumes parsed receive fields, a flow table lookup and a digest
// engine, all on the same clock as this block.
`timescale 1ns/1ps
`default_nettype none
module sfadm_framer (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        ce,
	input  wire logic                        priv_en,
	input  wire logic [sfadm_pkg::KEY_W-1:0] key_seq,
	input  wire logic [sfadm_pkg::FLOW_W-1:0] hmac_digest,
	input  wire logic                        sc_req_sent,
	input  wire logic [sfadm_pkg::TID_W-1:0] sc_req_tid,
	input  wire logic                        rx_valid,
	output logic                             rx_ready,
	input  wire sfadm_pkg::sfadm_msg_t       rx_type,
	input  wire logic [sfadm_pkg::TID_W-1:0] rx_tid,
	input  wire logic [sfadm_pkg::CONF_W-1:0] rx_conf,
	input  wire logic                        rx_params_ok,
	input  wire logic [sfadm_pkg::FLOW_W-1:0] rx_fail_flow,
	input  wire logic [sfadm_pkg::PAR_W-1:0] rx_fail_param,
	input  wire logic [sfadm_pkg::FLOW_W-1:0] rx_fixed_flow,
	input  wire logic                        rx_up_v,
	input  wire logic [sfadm_pkg::FLOW_W-1:0] rx_up_id,
	input  wire logic                        rx_dn_v,
	input  wire logic [sfadm_pkg::FLOW_W-1:0] rx_dn_id,
	input  wire logic                        rx_flows_found,
	input  wire logic                        cmd_valid,
	output logic                             cmd_ready,
	input  wire logic [sfadm_pkg::FLOW_W-1:0] cmd_fixed_flow,
	input  wire logic                        cmd_up_v,
	input  wire logic [sfadm_pkg::FLOW_W-1:0] cmd_up_id,
	input  wire logic                        cmd_dn_v,
	input  wire logic [sfadm_pkg::FLOW_W-1:0] cmd_dn_id,
	output logic                             tx_valid,
	input  wire logic                        tx_ready,
	output sfadm_pkg::sfadm_msg_t            tx_msg,
	output sfadm_pkg::sfadm_beat_t           tx_kind,
	output logic [sfadm_pkg::TID_W-1:0]      tx_tid,
	output logic [sfadm_pkg::CONF_W-1:0]     tx_conf,
	output logic [sfadm_pkg::FLOW_W-1:0]     tx_data,
	output logic [sfadm_pkg::PAR_W-1:0]      tx_aux,
	output logic                             tx_last,
	output logic                             del_exec,
	output logic                             del_first_v,
	output logic [sfadm_pkg::FLOW_W-1:0]     del_first_id,
	output logic                             del_second_v,
	output logic [sfadm_pkg::FLOW_W-1:0]     del_second_id,
	output logic                             del_done,
	output logic [sfadm_pkg::CONF_W-1:0]     del_done_conf,
	output logic                             rx_discard
);
	import sfadm_pkg::*;

	typedef struct packed {
		sfadm_beat_t        st;
		sfadm_msg_t         msg;
		logic [TID_W-1:0]   tid;
		logic [CONF_W-1:0]  conf;
		logic [FLOW_W-1:0]  fixed;
		logic               err;
		logic [FLOW_W-1:0]  eflow;
		logic [PAR_W-1:0]   eparam;
		logic               up_v;
		logic [FLOW_W-1:0]  up_id;
		logic               dn_v;
		logic [FLOW_W-1:0]  dn_id;
		logic               priv;
		logic [KEY_W-1:0]   key;
		logic [FLOW_W-1:0]  data;
		logic [PAR_W-1:0]   aux;
		logic               last;
		logic               sc_v;
		logic [TID_W-1:0]   sc_tid;
		logic               del_v;
		logic [TID_W-1:0]   del_tid;
		logic [TID_W-1:0]   tid_ctr;
		logic               done;
		logic [CONF_W-1:0]  dconf;
		logic               discard;
		logic               x_v;
		logic               xa_v;
		logic [FLOW_W-1:0]  xa;
		logic               xb_v;
		logic [FLOW_W-1:0]  xb;
	} sfadm_state_t;

	sfadm_state_t s_q;
	sfadm_state_t s_d;
	logic         rx_fire;
	logic         cmd_fire;

	// Ordering puts error set, flows, key sequence, then digest last.
	function automatic sfadm_beat_t next_beat(
		input sfadm_beat_t b,
		input sfadm_state_t m
	);
		sfadm_beat_t r;
		r = BEAT_IDLE;
		if (b == BEAT_KEY)
			r = BEAT_MAC;
		else if (m.priv && b != BEAT_MAC)
			r = BEAT_KEY;
		if (m.dn_v && (b == BEAT_HDR || b == BEAT_ERR ||
		    b == BEAT_FUP))
			r = BEAT_FDN;
		if (m.up_v && (b == BEAT_HDR || b == BEAT_ERR))
			r = BEAT_FUP;
		if (m.err && b == BEAT_HDR)
			r = BEAT_ERR;
		return r;
	endfunction

	// Every attribute after the header is a tagged beat of its own.
	function automatic logic [FLOW_W-1:0] beat_data(
		input sfadm_beat_t b,
		input sfadm_state_t m,
		input logic [FLOW_W-1:0] dig
	);
		logic [FLOW_W-1:0] r;
		r = '0;
		unique case (b)
			BEAT_HDR:  r = m.fixed;
			BEAT_ERR:  r = m.eflow;
			BEAT_FUP:  r = m.up_id;
			BEAT_FDN:  r = m.dn_id;
			BEAT_KEY:  r = {{(FLOW_W-KEY_W){1'b0}}, m.key};
			BEAT_MAC:  r = dig;
			BEAT_IDLE: r = '0;
		endcase
		return r;
	endfunction

	// Clears only the per-message fields, so flow results, the pending
	// delete, the last delete code and the id counter survive a new message.
	function automatic sfadm_state_t fresh(
		input sfadm_state_t m
	);
		sfadm_state_t r;
		r = m;
		r.conf = '0;
		r.fixed = '0;
		r.err = 1'b0;
		r.eflow = '0;
		r.eparam = '0;
		r.up_v = 1'b0;
		r.up_id = '0;
		r.dn_v = 1'b0;
		r.dn_id = '0;
		return r;
	endfunction

	assign rx_ready  = (s_q.st == BEAT_IDLE);
	// Received messages win; a local delete waits for a free framer.
	assign cmd_ready = (s_q.st == BEAT_IDLE) && !rx_valid && !s_q.del_v;
	assign rx_fire   = rx_valid && rx_ready;
	assign cmd_fire  = cmd_valid && cmd_ready;

	always_comb begin
		logic ld;
		logic ok;
		ld = 1'b0;
		ok = 1'b0;
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.discard = 1'b0;
		s_d.x_v = 1'b0;
		if (s_q.st != BEAT_IDLE && tx_ready) begin
			s_d.st = next_beat(s_q.st, s_q);
			ld = 1'b1;
		end
		if (rx_fire) begin
			unique case (rx_type)
				MSG_SC_RSP: begin
					if (s_q.sc_v && rx_tid == s_q.sc_tid) begin
						ok = (rx_conf == CONF_OK) && rx_params_ok;
						s_d = fresh(s_d);
						s_d.sc_v = 1'b0;
						s_d.st = BEAT_HDR;
						s_d.msg = MSG_SC_ACK;
						s_d.tid = s_q.sc_tid;
						if (ok)
							s_d.conf = CONF_OK;
						else if (rx_conf != CONF_OK)
							s_d.conf = rx_conf;
						else
							s_d.conf = CONF_REJECT;
						s_d.err = !ok;
						s_d.eflow = rx_fail_flow;
						s_d.eparam = rx_fail_param;
						ld = 1'b1;
					end else begin
						s_d.discard = 1'b1;
					end
				end
				MSG_DEL_REQ: begin
					s_d = fresh(s_d);
					s_d.st = BEAT_HDR;
					s_d.msg = MSG_DEL_RSP;
					s_d.tid = rx_tid;
					s_d.conf = rx_flows_found ? CONF_OK
						: CONF_NOT_FOUND;
					s_d.x_v = rx_flows_found;
					if (rx_fixed_flow != '0) begin
						s_d.xa_v = 1'b1;
						s_d.xa = rx_fixed_flow;
						s_d.xb_v = 1'b0;
						s_d.xb = '0;
					end else begin
						s_d.xa_v = rx_up_v;
						s_d.xa = rx_up_id;
						s_d.xb_v = rx_dn_v;
						s_d.xb = rx_dn_id;
					end
					ld = 1'b1;
				end
				MSG_DEL_RSP: begin
					if (s_q.del_v && rx_tid == s_q.del_tid) begin
						s_d.del_v = 1'b0;
						s_d.done = 1'b1;
						s_d.dconf = rx_conf;
					end else begin
						s_d.discard = 1'b1;
					end
				end
				default: s_d.discard = 1'b1;
			endcase
		end else if (cmd_fire) begin
			s_d = fresh(s_d);
			s_d.st = BEAT_HDR;
			s_d.msg = MSG_DEL_REQ;
			s_d.tid = s_q.tid_ctr;
			s_d.tid_ctr = s_q.tid_ctr + TID_STEP;
			s_d.del_v = 1'b1;
			s_d.del_tid = s_q.tid_ctr;
			s_d.conf = CONF_OK;
			s_d.fixed = cmd_fixed_flow;
			s_d.up_v = (cmd_fixed_flow == '0) && cmd_up_v;
			s_d.up_id = cmd_up_id;
			s_d.dn_v = (cmd_fixed_flow == '0) && cmd_dn_v;
			s_d.dn_id = cmd_dn_id;
			ld = 1'b1;
		end
		if (rx_fire && rx_type != MSG_DEL_RSP) begin
			s_d.dconf = s_q.dconf;
		end
		if (ld && s_q.st == BEAT_IDLE) begin
			s_d.priv = priv_en;
			s_d.key = key_seq;
		end
		if (ld) begin
			s_d.data = beat_data(s_d.st, s_d, hmac_digest);
			s_d.aux = (s_d.st == BEAT_ERR) ? s_d.eparam : '0;
			s_d.last = (next_beat(s_d.st, s_d) == BEAT_IDLE);
		end
		// A new request id arriving with a match still takes hold.
		if (sc_req_sent) begin
			s_d.sc_v = 1'b1;
			s_d.sc_tid = sc_req_tid;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.tid_ctr <= TID_RESET;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign tx_valid      = (s_q.st != BEAT_IDLE);
	assign tx_msg        = s_q.msg;
	assign tx_kind       = s_q.st;
	assign tx_tid        = s_q.tid;
	assign tx_conf       = s_q.conf;
	assign tx_data       = s_q.data;
	assign tx_aux        = s_q.aux;
	assign tx_last       = s_q.last;
	assign del_exec      = s_q.x_v;
	assign del_first_v   = s_q.xa_v;
	assign del_first_id  = s_q.xa;
	assign del_second_v  = s_q.xb_v;
	assign del_second_id = s_q.xb;
	assign del_done      = s_q.done;
	assign del_done_conf = s_q.dconf;
	assign rx_discard    = s_q.discard;

	property p_ack_reply;
		@(posedge clk) disable iff (!nrst)
		ce && rx_fire && rx_type == MSG_SC_RSP &&
		s_q.sc_v && rx_tid == s_q.sc_tid |=>
		tx_valid && tx_msg == MSG_SC_ACK && tx_kind == BEAT_HDR &&
		tx_tid == $past(rx_tid);
	endproperty
	a_ack_reply: assert property (p_ack_reply)
		else $error("acknowledge not started with request id");

	property p_ack_errset;
		@(posedge clk) disable iff (!nrst)
		tx_valid && tx_msg == MSG_SC_ACK |->
		s_q.err == (tx_conf != CONF_OK);
	endproperty
	a_ack_errset: assert property (p_ack_errset)
		else $error("error set presence disagrees with code");

	property p_mac_last;
		@(posedge clk) disable iff (!nrst)
		tx_valid && tx_kind == BEAT_MAC |-> tx_last;
	endproperty
	a_mac_last: assert property (p_mac_last)
		else $error("digest beat is not the last beat");

	property p_priv_end;
		@(posedge clk) disable iff (!nrst)
		tx_valid && tx_last && s_q.priv |->
		tx_kind == BEAT_MAC;
	endproperty
	a_priv_end: assert property (p_priv_end)
		else $error("private message ends without digest");

	property p_fixed_no_tlv;
		@(posedge clk) disable iff (!nrst)
		tx_valid && tx_msg == MSG_DEL_REQ && s_q.fixed != '0 |->
		tx_kind != BEAT_FUP && tx_kind != BEAT_FDN;
	endproperty
	a_fixed_no_tlv: assert property (p_fixed_no_tlv)
		else $error("flow TLV sent beside fixed flow id");

	property p_drsp_reply;
		@(posedge clk) disable iff (!nrst)
		ce && rx_fire && rx_type == MSG_DEL_REQ |=>
		tx_msg == MSG_DEL_RSP && tx_tid == $past(rx_tid) &&
		(tx_conf == CONF_OK) == $past(rx_flows_found);
	endproperty
	a_drsp_reply: assert property (p_drsp_reply)
		else $error("delete response id or code wrong");

	property p_ignore_tlv;
		@(posedge clk) disable iff (!nrst)
		ce && rx_fire && rx_type == MSG_DEL_REQ &&
		rx_fixed_flow != '0 |=>
		!del_second_v && del_first_id == $past(rx_fixed_flow);
	endproperty
	a_ignore_tlv: assert property (p_ignore_tlv)
		else $error("TLV flow used beside fixed flow id");

	property p_discard;
		@(posedge clk) disable iff (!nrst)
		ce && rx_fire && rx_type == MSG_DEL_RSP &&
		!(s_q.del_v && rx_tid == s_q.del_tid) |=>
		rx_discard && !del_done;
	endproperty
	a_discard: assert property (p_discard)
		else $error("unmatched delete response not dropped");

	property p_unique_tid;
		@(posedge clk) disable iff (!nrst)
		ce && cmd_fire |=> tx_tid == $past(s_q.tid_ctr) &&
		s_q.tid_ctr != tx_tid ##1 tx_tid == $past(tx_tid);
	endproperty
	a_unique_tid: assert property (p_unique_tid)
		else $error("delete request id not fresh");

	c_ack_err: cover property (@(posedge clk) disable iff (!nrst)
		tx_valid && tx_msg == MSG_SC_ACK && tx_kind == BEAT_ERR);
	c_dreq_tlv: cover property (@(posedge clk) disable iff (!nrst)
		tx_valid && tx_msg == MSG_DEL_REQ && tx_kind == BEAT_FDN);
	c_del_done: cover property (@(posedge clk) disable iff (!nrst)
		del_done);
	c_discard: cover property (@(posedge clk) disable iff (!nrst)
		rx_discard);
endmodule
`default_nettype wire

/* File: tb/sfadm_peer_model.sv */
// Peer MAC model on the far side of the framer's transmit path.
// Assumes the framer's tx handshake; logs every beat that it takes.
`timescale 1ns/1ps
`default_nettype none
module sfadm_peer_model (
	input  wire logic                         clk,
	input  wire logic                         nrst,
	input  wire logic                         slow,
	input  wire logic                         tx_valid,
	output logic                              tx_ready,
	input  wire sfadm_pkg::sfadm_msg_t        tx_msg,
	input  wire sfadm_pkg::sfadm_beat_t       tx_kind,
	input  wire logic [sfadm_pkg::TID_W-1:0]  tx_tid,
	input  wire logic [sfadm_pkg::CONF_W-1:0] tx_conf,
	input  wire logic [sfadm_pkg::FLOW_W-1:0] tx_data,
	input  wire logic [sfadm_pkg::PAR_W-1:0]  tx_aux,
	input  wire logic                         tx_last
);
	import sfadm_pkg::*;
	sfadm_beat_t       k[$];
	logic [FLOW_W-1:0] d[$];
	logic [PAR_W-1:0]  a[$];
	logic              l[$];
	sfadm_msg_t        h_msg;
	logic [TID_W-1:0]  h_tid;
	logic [CONF_W-1:0] h_conf;
	int                order_errs;
	logic              keyed;

	function automatic void clear();
		k.delete();
		d.delete();
		a.delete();
		l.delete();
	endfunction

	// A stalling peer is legal, and it shows beats that fail to hold.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_ready <= 1'b0;
			keyed <= 1'b0;
			order_errs <= 0;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			if (tx_valid && tx_ready) begin
				if (k.size() == 0) begin
					h_msg <= tx_msg;
					h_tid <= tx_tid;
					h_conf <= tx_conf;
				end
				k.push_back(tx_kind);
				d.push_back(tx_data);
				a.push_back(tx_aux);
				l.push_back(tx_last);
				keyed <= tx_last ? 1'b0 : (keyed || tx_kind == BEAT_KEY);
				// Once keyed, only the digest may close a message.
				if ((tx_kind == BEAT_MAC) !== (tx_last && keyed))
					order_errs <= order_errs + 1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/test_service_flow_ack_delete_msgs.sv */
// Bench for the flow acknowledge and delete framer with a peer model.
// Assumes one 20 MHz clock; each scenario judges its own results.
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
	fail_count++; $display("mismatch %s expected %h seen %h", n, e, g); \
	end end
module test_service_flow_ack_delete_msgs;
	import sfadm_pkg::*;
	logic              clk, nrst, ce, priv_en, sc_req_sent, rx_valid, slow;
	logic              rx_params_ok, rx_up_v, rx_dn_v, rx_flows_found;
	logic              cmd_valid, cmd_up_v, cmd_dn_v, rx_discard;
	logic              rx_ready, cmd_ready, tx_valid, tx_ready, tx_last;
	logic              del_exec, del_first_v, del_second_v, del_done;
	logic [KEY_W-1:0]  key_seq;
	logic [TID_W-1:0]  sc_req_tid, rx_tid, tx_tid;
	logic [CONF_W-1:0] rx_conf, tx_conf, del_done_conf;
	logic [PAR_W-1:0]  rx_fail_param, tx_aux;
	logic [FLOW_W-1:0] hmac_digest, rx_fail_flow, rx_fixed_flow, rx_up_id;
	logic [FLOW_W-1:0] rx_dn_id, cmd_fixed_flow, cmd_up_id, cmd_dn_id;
	logic [FLOW_W-1:0] tx_data, del_first_id, del_second_id;
	sfadm_msg_t        rx_type, tx_msg;
	sfadm_beat_t       tx_kind;
	int                fail_count, total_checks;

	sfadm_framer dut_u (.clk, .nrst, .ce, .priv_en, .key_seq, .hmac_digest,
		.sc_req_sent, .sc_req_tid, .rx_valid, .rx_ready, .rx_type, .rx_tid,
		.rx_conf, .rx_params_ok, .rx_fail_flow, .rx_fail_param,
		.rx_fixed_flow, .rx_up_v, .rx_up_id, .rx_dn_v, .rx_dn_id,
		.rx_flows_found, .cmd_valid, .cmd_ready, .cmd_fixed_flow, .cmd_up_v,
		.cmd_up_id, .cmd_dn_v, .cmd_dn_id, .tx_valid, .tx_ready, .tx_msg,
		.tx_kind, .tx_tid, .tx_conf, .tx_data, .tx_aux, .tx_last, .del_exec,
		.del_first_v, .del_first_id, .del_second_v, .del_second_id,
		.del_done, .del_done_conf, .rx_discard);
	sfadm_peer_model p (.clk, .nrst, .slow, .tx_valid, .tx_ready, .tx_msg,
		.tx_kind, .tx_tid, .tx_conf, .tx_data, .tx_aux, .tx_last);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic post_req(input logic [TID_W-1:0] id);
		@(posedge clk);
		sc_req_sent <= 1'b1;
		sc_req_tid <= id;
		@(posedge clk);
		sc_req_sent <= 1'b0;
	endtask

	// Pulses of the answer are looked at in the one cycle they stand.
	task automatic take_rx(input sfadm_msg_t ty, input logic [TID_W-1:0] id);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_type <= ty;
		rx_tid <= id;
		@(posedge clk);
		rx_valid <= 1'b0;
		#1;
	endtask

	task automatic take_cmd;
		@(posedge clk);
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		while (tx_valid !== 1'b0 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CK("tx idle", 1'b0, tx_valid)
	endtask

	task automatic hdr(input sfadm_msg_t m, input logic [TID_W-1:0] t,
		input logic [CONF_W-1:0] c);
		`CK("msg", m, p.h_msg)
		`CK("tid", t, p.h_tid)
		`CK("conf", c, p.h_conf)
	endtask

	task automatic beat(input int i, input sfadm_beat_t kd, input logic lt);
		`CK("beat kind", kd, p.k[i])
		`CK("beat last", lt, p.l[i])
	endtask

	task automatic t_ack_ok;
		p.clear();
		@(posedge clk);
		priv_en <= 1'b0;
		rx_conf <= CONF_OK;
		rx_params_ok <= 1'b1;
		post_req(16'h1234);
		take_rx(MSG_SC_RSP, 16'h1234);
		`CK("ack sent", 1'b1, tx_valid)
		`CK("discard", 1'b0, rx_discard)
		wait_idle();
		`CK("beats", 1, p.k.size())
		hdr(MSG_SC_ACK, 16'h1234, CONF_OK);
		beat(0, BEAT_HDR, 1'b1);
		$display("test ack_ok done");
	endtask

	task automatic t_ack_fail;
		p.clear();
		@(posedge clk);
		slow <= 1'b1;
		priv_en <= 1'b1;
		key_seq <= 4'hA;
		hmac_digest <= 32'hC0FFEE01;
		rx_params_ok <= 1'b0;
		rx_fail_flow <= 32'h00000077;
		rx_fail_param <= 8'h1C;
		post_req(16'hBEEF);
		take_rx(MSG_SC_RSP, 16'hBEEF);
		`CK("rx busy", 1'b0, rx_ready)
		wait_idle();
		`CK("beats", 4, p.k.size())
		hdr(MSG_SC_ACK, 16'hBEEF, CONF_REJECT);
		beat(1, BEAT_ERR, 1'b0);
		`CK("err flow", 32'h00000077, p.d[1])
		`CK("err param", 8'h1C, p.a[1])
		beat(2, BEAT_KEY, 1'b0);
		`CK("key", 4'hA, p.d[2][KEY_W-1:0])
		beat(3, BEAT_MAC, 1'b1);
		`CK("digest", 32'hC0FFEE01, p.d[3])
		$display("test ack_fail done");
	endtask

	task automatic t_stale;
		take_rx(MSG_SC_RSP, 16'h4321);
		`CK("stale ack drop", 1'b1, rx_discard)
		`CK("no answer", 1'b0, tx_valid)
		take_rx(MSG_DEL_RSP, 16'h0F0F);
		`CK("stale rsp drop", 1'b1, rx_discard)
		$display("test stale done");
	endtask

	task automatic t_del_cmd;
		p.clear();
		@(posedge clk);
		key_seq <= 4'h3;
		cmd_fixed_flow <= 32'h00000000;
		{cmd_up_v, cmd_dn_v} <= 2'h3;
		cmd_up_id <= 32'h00000011;
		cmd_dn_id <= 32'h00000022;
		take_cmd();
		wait_idle();
		`CK("beats", 5, p.k.size())
		hdr(MSG_DEL_REQ, TID_RESET, CONF_OK);
		`CK("fixed", 32'h00000000, p.d[0])
		beat(1, BEAT_FUP, 1'b0);
		`CK("up id", 32'h00000011, p.d[1])
		beat(2, BEAT_FDN, 1'b0);
		`CK("dn id", 32'h00000022, p.d[2])
		beat(4, BEAT_MAC, 1'b1);
		`CK("busy", 1'b0, cmd_ready)
		take_rx(MSG_DEL_RSP, TID_RESET);
		`CK("done", 1'b1, del_done)
		`CK("done conf", CONF_OK, del_done_conf)
		p.clear();
		@(posedge clk);
		slow <= 1'b0;
		cmd_fixed_flow <= 32'h00000099;
		take_cmd();
		wait_idle();
		`CK("beats", 3, p.k.size())
		hdr(MSG_DEL_REQ, TID_RESET + TID_STEP, CONF_OK);
		`CK("fixed", 32'h00000099, p.d[0])
		beat(1, BEAT_KEY, 1'b0);
		@(posedge clk);
		rx_conf <= CONF_NOT_FOUND;
		take_rx(MSG_DEL_RSP, TID_RESET + TID_STEP);
		`CK("done conf", CONF_NOT_FOUND, del_done_conf)
		$display("test del_cmd done");
	endtask

	task automatic t_del_rx;
		p.clear();
		@(posedge clk);
		priv_en <= 1'b0;
		rx_fixed_flow <= 32'h00000055;
		{rx_up_v, rx_dn_v, rx_flows_found} <= 3'h7;
		rx_up_id <= 32'h00000066;
		rx_dn_id <= 32'h00000077;
		take_rx(MSG_DEL_REQ, 16'h0777);
		`CK("exec", 1'b1, del_exec)
		`CK("first", 32'h00000055, del_first_id)
		`CK("second v", 1'b0, del_second_v)
		wait_idle();
		hdr(MSG_DEL_RSP, 16'h0777, CONF_OK);
		beat(0, BEAT_HDR, 1'b1);
		p.clear();
		@(posedge clk);
		rx_flows_found <= 1'b0;
		rx_fixed_flow <= 32'h00000000;
		take_rx(MSG_DEL_REQ, 16'h0778);
		`CK("no exec", 1'b0, del_exec)
		`CK("tlv first", 32'h00000066, del_first_id)
		`CK("tlv second v", 1'b1, del_second_v)
		`CK("tlv second", 32'h00000077, del_second_id)
		wait_idle();
		hdr(MSG_DEL_RSP, 16'h0778, CONF_NOT_FOUND);
		`CK("order", 0, p.order_errs)
		$display("test del_rx done");
	endtask

	initial begin
		{fail_count, total_checks} = '0;
		{nrst, priv_en, sc_req_sent, rx_valid, slow, cmd_valid} = '0;
		{rx_params_ok, rx_up_v, rx_dn_v, rx_flows_found} = '0;
		{cmd_up_v, cmd_dn_v, key_seq, sc_req_tid, rx_tid, rx_conf} = '0;
		{rx_fail_param, hmac_digest, rx_fail_flow, rx_fixed_flow} = '0;
		{rx_up_id, rx_dn_id, cmd_fixed_flow, cmd_up_id, cmd_dn_id} = '0;
		rx_type = MSG_NONE;
		ce = 1'b1;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_ack_ok();
		t_ack_fail();
		t_stale();
		t_del_cmd();
		t_del_rx();
		report_and_stop();
	end

	// The scenarios need well under a thousand cycles.
	initial begin
		#500000;
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
